// *** hw/drt_top.sv ***
// Refresh, leveling, termination, calibration and readout timing logic
// What this block does
// - Termination turns off within a cycle of the off-latency reference edge.
// - Internal write starts write latency plus 4 cycles, or plus 2 instead for fixed chop.
// - Power-down takes effect only after pending row and refresh work ends.
// - A short calibration steps the impedance code within 64 cycles.
// - Readout register returns the fixed calibration bit pattern on reads.
module drt_top
    import drt_pkg::*;
(
    // Core clock domain
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic core_ce,
    input wire logic high_temp,
    // Link clock and command pins
    input wire logic link_clk,
    input wire logic cke,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    input wire logic odt,
    // Leveling strobe activity
    input wire logic dqs_drive_en,
    input wire logic dqs_rise,
    // Calibration target
    input wire logic [5:0] zq_target,
    // Link-side results
    output logic write_start_reg,
    output logic rtt_enable_reg,
    output logic zq_busy_reg,
    output logic [5:0] zq_code_reg,
    output logic rdo_valid_reg,
    output logic [1:0] rdo_data_reg,
    output logic leveling_err_reg,
    // Core-side results
    output logic power_down_reg,
    output logic refresh_busy_reg,
    output logic refresh_late_reg,
    output logic timing_err_reg
);
    // Link domain
    logic ce_l;
    logic cmd_hit;
    logic [2:0] cmd;
    logic [1:0] bl_mode_reg;
    logic [2:0] cwl_code_reg;
    logic wlvl_reg;
    logic rdo_en_reg;
    logic [4:0] wr_lat;
    logic [31:0] wr_pipe_reg;
    logic [31:0] odt_pipe_reg;
    logic [4:0] wr_tap;
    logic [4:0] odt_tap;
    logic [6:0] zq_cnt_reg;
    logic [5:0] lvl_cnt_reg;
    logic [2:0] rdo_left_reg;
    logic [1:0] rdo_idx_reg;
    logic ref_tog_reg;
    logic act_tog_reg;
    logic pre_tog_reg;
    logic cke_low_reg;

    drt_sync #(.WIDTH(1)) u_ce_sync (
        .clk(link_clk),
        .rst_b(rst_b),
        .async_in(core_ce),
        .sync_out(ce_l)
    );

    assign cmd = {ras_b, cas_b, we_b};
    assign cmd_hit = !cs_b && cke;
    assign wr_lat = CWL_BASE + {2'b00, cwl_code_reg};
    // Fixed chop shortens the start of the internal write
    assign wr_tap = (bl_mode_reg == BL_FIXED4) ?
        5'(wr_lat + WRITE_START_BC4_OFFSET - 5'd2) : 5'(wr_lat + WRITE_START_BL8_OFFSET - 5'd2);
    assign odt_tap = 5'(wr_lat - TERM_OFF_LATENCY_OFFSET - 5'd2);

    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            bl_mode_reg <= MR0_BL_RESET;
            cwl_code_reg <= MR2_CWL_RESET;
            wlvl_reg <= 1'b0;
            rdo_en_reg <= 1'b0;
        end else if (ce_l && cmd_hit && cmd == CMD_MRS) begin
            case (ba)
                MR0_SEL: bl_mode_reg <= addr[MR0_BL_POS +: 2];
                MR1_SEL: wlvl_reg <= addr[MR1_WLVL_POS];
                MR2_SEL: cwl_code_reg <= addr[MR2_CWL_POS +: 3];
                MR3_SEL: rdo_en_reg <= addr[MR3_RDO_POS];
                default: rdo_en_reg <= rdo_en_reg;
            endcase
        end
    end

    // Write start and termination delay lines
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pipe_reg <= '0;
            odt_pipe_reg <= '0;
            write_start_reg <= 1'b0;
            rtt_enable_reg <= 1'b0;
        end else if (ce_l) begin
            wr_pipe_reg <= {wr_pipe_reg[30:0], cmd_hit && cmd == CMD_WR && !rdo_en_reg};
            odt_pipe_reg <= {odt_pipe_reg[30:0], odt};
            write_start_reg <= wr_pipe_reg[wr_tap];
            // Off edge lands on the reference edge, inside the window
            rtt_enable_reg <= odt_pipe_reg[odt_tap];
        end
    end

    // Short calibration: one code step per command
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            zq_cnt_reg <= '0;
            zq_busy_reg <= 1'b0;
            zq_code_reg <= ZQ_CODE_RESET;
        end else if (ce_l) begin
            if (cmd_hit && cmd == CMD_ZQ && !addr[ADDR_ZQL_POS] && !zq_busy_reg) begin
                zq_cnt_reg <= ZQCS_CYCLES - 7'd1;
                zq_busy_reg <= 1'b1;
            end else if (zq_busy_reg) begin
                zq_cnt_reg <= zq_cnt_reg - 7'd1;
                if (zq_cnt_reg == 7'd1) begin
                    zq_busy_reg <= 1'b0;
                    if (zq_code_reg < zq_target) begin
                        zq_code_reg <= zq_code_reg + 6'd1;
                    end else if (zq_code_reg > zq_target) begin
                        zq_code_reg <= zq_code_reg - 6'd1;
                    end
                end
            end
        end
    end

    // Leveling entry timing watch
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            lvl_cnt_reg <= '0;
            leveling_err_reg <= 1'b0;
        end else if (ce_l) begin
            if (cmd_hit && cmd == CMD_MRS && ba == MR1_SEL && addr[MR1_WLVL_POS]) begin
                lvl_cnt_reg <= 6'd1; // Next edge is one full cycle after entry
                leveling_err_reg <= 1'b0;
            end else if (wlvl_reg) begin
                if (lvl_cnt_reg != 6'h3f) begin
                    lvl_cnt_reg <= lvl_cnt_reg + 6'd1;
                end
                if ((dqs_drive_en && lvl_cnt_reg < LEVELING_STROBE_ENABLE_DELAY) ||
                    (dqs_rise && lvl_cnt_reg < LEVELING_FIRST_STROBE_DELAY)) begin
                    leveling_err_reg <= 1'b1;
                end
            end
        end
    end

    // Readout bursts: two beats per link cycle
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdo_left_reg <= '0;
            rdo_idx_reg <= '0;
            rdo_valid_reg <= 1'b0;
            rdo_data_reg <= '0;
        end else if (ce_l) begin
            if (cmd_hit && cmd == CMD_RD && rdo_en_reg) begin
                // Chop when fixed, or on the fly with the chop bit low
                if (bl_mode_reg == BL_FIXED4 ||
                    (bl_mode_reg == BL_OTF && !addr[ADDR_BC_POS])) begin
                    rdo_left_reg <= 3'd2;
                    rdo_idx_reg <= {addr[ADDR_NIBBLE_POS], 1'b0};
                end else begin
                    rdo_left_reg <= 3'd4;
                    rdo_idx_reg <= 2'd0;
                end
            end else if (rdo_left_reg != 3'd0) begin
                rdo_left_reg <= rdo_left_reg - 3'd1;
                rdo_idx_reg <= rdo_idx_reg + 2'd1;
            end
            rdo_valid_reg <= (rdo_left_reg != 3'd0);
            rdo_data_reg <= RDO_PATTERN[{rdo_idx_reg, 1'b0} +: 2];
        end
    end

    // Events toward the core domain travel as toggles
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_tog_reg <= 1'b0;
            act_tog_reg <= 1'b0;
            pre_tog_reg <= 1'b0;
            cke_low_reg <= 1'b0;
        end else if (ce_l) begin
            cke_low_reg <= !cke;
            if (cmd_hit && cmd == CMD_REF) begin
                ref_tog_reg <= !ref_tog_reg;
            end
            if (cmd_hit && cmd == CMD_ACT) begin
                act_tog_reg <= !act_tog_reg;
            end
            if (cmd_hit && cmd == CMD_PRE) begin
                pre_tog_reg <= !pre_tog_reg;
            end
        end
    end

    // Core domain
    logic [4:0] core_sync;
    logic [2:0] tog_prev_reg;
    logic ref_seen;
    logic row_seen;
    logic [4:0] ref_cnt_reg;
    logic [1:0] row_cnt_reg;
    logic [9:0] ivl_cnt_reg;
    logic [9:0] ivl_limit;

    drt_sync #(.WIDTH(5)) u_core_sync (
        .clk(core_clk),
        .rst_b(rst_b),
        .async_in({high_temp, cke_low_reg, pre_tog_reg, act_tog_reg, ref_tog_reg}),
        .sync_out(core_sync)
    );

    assign ref_seen = core_sync[0] ^ tog_prev_reg[0];
    assign row_seen = (core_sync[1] ^ tog_prev_reg[1]) || (core_sync[2] ^ tog_prev_reg[2]);
    assign ivl_limit = core_sync[4] ?
        10'(REFRESH_INTERVAL_HOT_CYCLES) : 10'(REFRESH_INTERVAL_CYCLES);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tog_prev_reg <= '0;
            ref_cnt_reg <= '0;
            row_cnt_reg <= '0;
            refresh_busy_reg <= 1'b0;
            power_down_reg <= 1'b0;
        end else if (core_ce) begin
            tog_prev_reg <= core_sync[2:0];
            if (ref_seen) begin
                ref_cnt_reg <= 5'(REFRESH_CYCLE_CYCLES);
            end else if (ref_cnt_reg != 5'd0) begin
                ref_cnt_reg <= ref_cnt_reg - 5'd1;
            end
            if (row_seen) begin
                row_cnt_reg <= 2'(ROW_OP_CYCLES);
            end else if (row_cnt_reg != 2'd0) begin
                row_cnt_reg <= row_cnt_reg - 2'd1;
            end
            refresh_busy_reg <= ref_seen || ref_cnt_reg > 5'd1;
            // CKE low is honoured only once pending work is over
            power_down_reg <= core_sync[3] && !ref_seen && !row_seen &&
                ref_cnt_reg == 5'd0 && row_cnt_reg == 2'd0;
        end
    end

    // Watches on the controller side; late flag sticky until reset or refresh, timing flag until reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ivl_cnt_reg <= '0;
            refresh_late_reg <= 1'b0;
            timing_err_reg <= 1'b0;
        end else if (core_ce) begin
            if (ref_seen) begin
                ivl_cnt_reg <= '0;
                refresh_late_reg <= 1'b0;
            end else if (ivl_cnt_reg >= ivl_limit) begin
                refresh_late_reg <= 1'b1;
            end else begin
                ivl_cnt_reg <= ivl_cnt_reg + 10'd1;
            end
            if ((ref_seen || (core_sync[1] ^ tog_prev_reg[1])) && ref_cnt_reg != 5'd0) begin
                timing_err_reg <= 1'b1;
            end
        end
    end

    // Checks
    property p_write_start_bl8;
        @(posedge link_clk) disable iff (!rst_b || !ce_l)
        (cmd_hit && cmd == CMD_WR && !rdo_en_reg && cwl_code_reg == 3'd0 &&
         bl_mode_reg != BL_FIXED4) |-> !write_start_reg ##9 write_start_reg;
    endproperty
    a_write_start_bl8: assert property (p_write_start_bl8) else $error("write start late");

    property p_write_start_bc4;
        @(posedge link_clk) disable iff (!rst_b || !ce_l)
        (cmd_hit && cmd == CMD_WR && !rdo_en_reg && cwl_code_reg == 3'd0 &&
         bl_mode_reg == BL_FIXED4 && wr_pipe_reg[6:0] == 7'd0) |->
            ##6 !write_start_reg ##1 write_start_reg;
    endproperty
    a_write_start_bc4: assert property (p_write_start_bc4) else $error("chop start wrong");

    property p_term_off;
        @(posedge link_clk) disable iff (!rst_b || !ce_l)
        (!odt && odt_pipe_reg[2:0] == 3'b111 && cwl_code_reg == 3'd0) |->
            ##2 rtt_enable_reg ##1 !rtt_enable_reg;
    endproperty
    a_term_off: assert property (p_term_off) else $error("termination off mistimed");

    property p_zq_window;
        @(posedge link_clk) disable iff (!rst_b || !ce_l)
        $rose(zq_busy_reg) |-> ##62 zq_busy_reg ##1 !zq_busy_reg;
    endproperty
    a_zq_window: assert property (p_zq_window) else $error("calibration not in 64 cycles");

    property p_rdo_burst;
        @(posedge link_clk) disable iff (!rst_b || !ce_l)
        (cmd_hit && cmd == CMD_RD && rdo_en_reg && bl_mode_reg == BL_FIXED8 &&
         rdo_left_reg == 3'd0) |-> ##2 (rdo_valid_reg && rdo_data_reg == 2'b10) [*4]
            ##1 !rdo_valid_reg;
    endproperty
    a_rdo_burst: assert property (p_rdo_burst) else $error("readout burst wrong");

    property p_pd_held_off;
        @(posedge core_clk) disable iff (!rst_b || !core_ce)
        ref_seen |-> ##1 (!power_down_reg && refresh_busy_reg) [*8];
    endproperty
    a_pd_held_off: assert property (p_pd_held_off) else $error("power-down during refresh");

    c_zq_done: cover property (@(posedge link_clk) disable iff (!rst_b) $fell(zq_busy_reg));
    c_rdo_read: cover property (@(posedge link_clk) disable iff (!rst_b) $rose(rdo_valid_reg));
    c_write_start: cover property (@(posedge link_clk) disable iff (!rst_b) write_start_reg);
    c_power_down: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(power_down_reg));
endmodule

// *** hw/drt_pkg.sv ***
// Constants shared by the refresh, leveling and timing block
package drt_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Refresh busy time, least time rounds up
    localparam int REFRESH_CYCLE_TIME_NS = 260;
    localparam int REFRESH_CYCLE_CYCLES =
        (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Average refresh interval, longest time rounds down
    localparam int REFRESH_INTERVAL_AVG_NS = 7800;
    localparam int REFRESH_INTERVAL_HOT_NS = 3900;
    localparam int REFRESH_INTERVAL_CYCLES = REFRESH_INTERVAL_AVG_NS / CLK_PERIOD_NS;
    localparam int REFRESH_INTERVAL_HOT_CYCLES = REFRESH_INTERVAL_HOT_NS / CLK_PERIOD_NS;
    // Row activate or precharge busy time
    localparam int ROW_OP_TIME_NS = 15;
    localparam int ROW_OP_CYCLES = (ROW_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Link-clock counts
    localparam logic [5:0] LEVELING_FIRST_STROBE_DELAY = 6'd40;
    localparam logic [5:0] LEVELING_STROBE_ENABLE_DELAY = 6'd25;
    localparam logic [6:0] ZQCS_CYCLES = 7'd64;
    localparam logic [4:0] WRITE_START_BL8_OFFSET = 5'd4;
    localparam logic [4:0] WRITE_START_BC4_OFFSET = 5'd2;
    localparam logic [4:0] TERM_OFF_LATENCY_OFFSET = 5'd2;
    localparam logic [4:0] CWL_BASE = 5'd5;
    // Command codes {ras_b, cas_b, we_b}
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_ZQ = 3'h6;
    // Mode register selects and fields
    localparam logic [2:0] MR0_SEL = 3'h0;
    localparam logic [2:0] MR1_SEL = 3'h1;
    localparam logic [2:0] MR2_SEL = 3'h2;
    localparam logic [2:0] MR3_SEL = 3'h3;
    localparam int MR0_BL_POS = 0;
    localparam int MR1_WLVL_POS = 7;
    localparam int MR2_CWL_POS = 3;
    localparam int MR3_RDO_POS = 2;
    localparam int ADDR_BC_POS = 12;
    localparam int ADDR_ZQL_POS = 10;
    localparam int ADDR_NIBBLE_POS = 2;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    // Readout pattern, burst bit 0 in the lsb
    localparam logic [7:0] RDO_PATTERN = 8'haa;
    // Reset values
    localparam logic [1:0] MR0_BL_RESET = 2'h0;
    localparam logic [2:0] MR2_CWL_RESET = 3'h0;
    localparam logic [5:0] ZQ_CODE_RESET = 6'h20;
endpackage

// *** hw/drt_sync.sv ***
// Two flip-flop level synchroniser
module drt_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// *** tb/drt_ctrl_model.sv ***
// Controller model driving the command, termination and strobe pins
module drt_ctrl_model
    import drt_pkg::*;
(
    // Link clock
    input wire logic link_clk,
    // Command and termination pins
    output logic cke,
    output logic cs_b,
    output logic ras_b,
    output logic cas_b,
    output logic we_b,
    output logic [2:0] ba,
    output logic [12:0] addr,
    output logic odt,
    // Strobe activity
    output logic dqs_drive_en,
    output logic dqs_rise
);
    time last_ref;
    initial begin
        last_ref = 0;
        cke = 1'b1;
        cs_b = 1'b1;
        {ras_b, cas_b, we_b} = 3'h7;
        ba = 3'h0;
        addr = 13'h0;
        odt = 1'b0;
        dqs_drive_en = 1'b0;
        dqs_rise = 1'b0;
    end
    // Reads only go out after reset, DLL taken as locked
    task automatic issue(input logic [2:0] cmd, input logic [2:0] sel,
        input logic [12:0] a, input bit rush);
        // Rush is only set by a scenario that wants the violation
        if (!rush && (cmd == CMD_REF || cmd == CMD_ACT)) begin
            while ($time < last_ref + REFRESH_CYCLE_TIME_NS) @(negedge link_clk);
        end
        @(negedge link_clk);
        cs_b = 1'b0;
        {ras_b, cas_b, we_b} = cmd;
        ba = sel;
        addr = a;
        @(negedge link_clk);
        if (cmd == CMD_REF) begin
            last_ref = $time;
        end
        // Idle pins flip so a stale command never looks held
        cs_b = 1'b1;
        {ras_b, cas_b, we_b} = ~cmd;
        ba = ~sel;
        addr = ~a;
    endtask
    // CKE drops only after the refresh edge has passed
    task automatic pins(input logic ce, input logic term);
        @(negedge link_clk);
        cke = ce;
        odt = term;
    endtask
    // Strobe enable and first rise counted from leveling entry
    task automatic strobe(input int n_en, input int n_rise);
        repeat (n_en - 1) @(negedge link_clk);
        dqs_drive_en = 1'b1;
        repeat (n_rise - n_en) @(negedge link_clk);
        dqs_rise = 1'b1;
        @(negedge link_clk);
        dqs_rise = 1'b0;
        dqs_drive_en = 1'b0;
    endtask
    // Write recovery in ns, rounded up to whole link cycles
    localparam int WRITE_RECOVERY_TIME_NS = 15;
    localparam int LINK_PERIOD_NS = 15;
    // Gap a write must leave before CKE may drop
    task automatic write_to_powerdown(input int wr_lat);
        repeat (wr_lat + 4 + (WRITE_RECOVERY_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS)
            @(negedge link_clk);
    endtask
endmodule

// *** tb/drt_top_tb_top.sv ***
// Self-checking bench for the refresh, leveling and timing block
module drt_top_tb_top
    import drt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, link_clk, rst_b, core_ce, high_temp;
    logic cke, cs_b, ras_b, cas_b, we_b, odt, dqs_drive_en, dqs_rise;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [5:0] zq_target, zq_code_reg;
    logic [1:0] rdo_data_reg;
    logic write_start_reg, rtt_enable_reg, zq_busy_reg, rdo_valid_reg, leveling_err_reg;
    logic power_down_reg, refresh_busy_reg, refresh_late_reg, timing_err_reg;
    int error_cnt = 0;
    int checked = 0;
    int n;
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    // Link period fits both CAS latencies at once
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    drt_ctrl_model u_ctrl (.link_clk(link_clk), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
        .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr), .odt(odt),
        .dqs_drive_en(dqs_drive_en), .dqs_rise(dqs_rise));
    drt_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .core_ce(core_ce),
        .high_temp(high_temp), .link_clk(link_clk), .cke(cke), .cs_b(cs_b),
        .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr), .odt(odt),
        .dqs_drive_en(dqs_drive_en), .dqs_rise(dqs_rise), .zq_target(zq_target),
        .write_start_reg(write_start_reg), .rtt_enable_reg(rtt_enable_reg),
        .zq_busy_reg(zq_busy_reg), .zq_code_reg(zq_code_reg),
        .rdo_valid_reg(rdo_valid_reg), .rdo_data_reg(rdo_data_reg),
        .leveling_err_reg(leveling_err_reg), .power_down_reg(power_down_reg),
        .refresh_busy_reg(refresh_busy_reg), .refresh_late_reg(refresh_late_reg),
        .timing_err_reg(timing_err_reg));
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic lw(input int k);
        repeat (k) @(negedge link_clk);
    endtask
    function automatic logic flag(input int sel);
        case (sel)
            0: return refresh_busy_reg;
            1: return power_down_reg;
            default: return refresh_late_reg;
        endcase
    endfunction
    // Bounded wait on a core flag; a spent bound ends the run
    task automatic wait_core(input int sel, input logic val, input int lim);
        n = 0;
        while (flag(sel) !== val) begin
            @(negedge core_clk);
            n++;
            if (n > lim) begin
                chk(8'h0, 8'h1);
                complete_run();
            end
        end
    endtask
    task automatic t_reset();
        chk({write_start_reg, rtt_enable_reg, zq_busy_reg, rdo_valid_reg,
            leveling_err_reg, power_down_reg, refresh_busy_reg, timing_err_reg}, 8'h0);
        chk({refresh_late_reg, rdo_data_reg, 5'h0}, 8'h0);
        chk({2'h0, zq_code_reg}, 8'h20);
    endtask
    // Reset held three core cycles, then link edges for the enable sync
    task automatic t_rst();
        rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        t_reset();
        rst_b = 1'b1;
        lw(4);
    endtask
    // Write start per burst mode and write latency
    task automatic t_write();
        logic [1:0] mode [4] = '{BL_FIXED8, BL_FIXED4, BL_OTF, BL_FIXED8};
        logic [2:0] cwl [4] = '{3'h2, 3'h0, 3'h0, 3'h0};
        int off [4] = '{4, 2, 4, 4};
        for (int i = 0; i < 4; i++) begin
            u_ctrl.issue(CMD_MRS, MR0_SEL, 13'(mode[i]), 1'b0);
            u_ctrl.issue(CMD_MRS, MR2_SEL, 13'(cwl[i]) << MR2_CWL_POS, 1'b0);
            u_ctrl.issue(CMD_WR, 3'h0, 13'h0, 1'b0);
            lw(5 + int'(cwl[i]) + off[i] - 2);
            chk(8'(write_start_reg), 8'h0);
            lw(1);
            chk(8'(write_start_reg), 8'h1);
            lw(1);
            chk(8'(write_start_reg), 8'h0);
        end
        u_ctrl.write_to_powerdown(5);
    endtask
    task automatic t_odt();
        u_ctrl.pins(1'b1, 1'b1);
        lw(8);
        chk(8'(rtt_enable_reg), 8'h1);
        u_ctrl.pins(1'b1, 1'b0);
        lw(2);
        chk(8'(rtt_enable_reg), 8'h1);
        lw(1);
        chk(8'(rtt_enable_reg), 8'h0);
    endtask
    task automatic t_zq();
        zq_target = 6'h21;
        u_ctrl.issue(CMD_ZQ, 3'h0, 13'h1 << ADDR_ZQL_POS, 1'b0);
        lw(2);
        chk(8'(zq_busy_reg), 8'h0);
        u_ctrl.issue(CMD_ZQ, 3'h0, 13'h0, 1'b0);
        chk(8'(zq_busy_reg), 8'h1);
        lw(62);
        chk({zq_busy_reg, 1'b0, zq_code_reg}, 8'ha0);
        lw(1);
        chk({zq_busy_reg, 1'b0, zq_code_reg}, 8'h21);
    endtask
    // Readout burst, an ignored write, then a chopped upper-nibble read
    task automatic t_mpr();
        u_ctrl.issue(CMD_MRS, MR3_SEL, 13'h1 << MR3_RDO_POS, 1'b0);
        u_ctrl.issue(CMD_RD, 3'h0, 13'h0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            lw(1);
            chk({rdo_valid_reg, rdo_data_reg}, 8'h6);
        end
        lw(1);
        chk(8'(rdo_valid_reg), 8'h0);
        u_ctrl.issue(CMD_WR, 3'h0, 13'h0, 1'b0);
        for (int k = 0; k < 12; k++) begin
            lw(1);
            chk(8'(write_start_reg), 8'h0);
        end
        u_ctrl.issue(CMD_MRS, MR3_SEL, 13'h0, 1'b0);
        u_ctrl.issue(CMD_MRS, MR0_SEL, 13'(BL_OTF), 1'b0);
        u_ctrl.issue(CMD_MRS, MR3_SEL, 13'h1 << MR3_RDO_POS, 1'b0);
        u_ctrl.issue(CMD_RD, 3'h0, 13'h1 << ADDR_NIBBLE_POS, 1'b0);
        for (int k = 0; k < 2; k++) begin
            lw(1);
            chk({rdo_valid_reg, rdo_data_reg}, 8'h6);
        end
        lw(1);
        chk(8'(rdo_valid_reg), 8'h0);
        u_ctrl.issue(CMD_MRS, MR3_SEL, 13'h0, 1'b0);
    endtask
    task automatic t_level();
        u_ctrl.issue(CMD_MRS, MR1_SEL, 13'h1 << MR1_WLVL_POS, 1'b0);
        u_ctrl.strobe(25, 40);
        chk(8'(leveling_err_reg), 8'h0);
        u_ctrl.issue(CMD_MRS, MR1_SEL, 13'h0, 1'b0);
        u_ctrl.issue(CMD_MRS, MR1_SEL, 13'h1 << MR1_WLVL_POS, 1'b0);
        u_ctrl.strobe(5, 10);
        lw(2);
        chk(8'(leveling_err_reg), 8'h1);
        u_ctrl.issue(CMD_MRS, MR1_SEL, 13'h0, 1'b0);
    endtask
    // Refresh busy length, early refresh flagged, power-down held off
    task automatic t_refresh();
        u_ctrl.issue(CMD_REF, 3'h0, 13'h0, 1'b0);
        wait_core(0, 1'b1, 20);
        wait_core(0, 1'b0, 40);
        chk(8'(n), 8'd26);
        chk(8'(timing_err_reg), 8'h0);
        u_ctrl.issue(CMD_REF, 3'h0, 13'h0, 1'b0);
        u_ctrl.issue(CMD_REF, 3'h0, 13'h0, 1'b1);
        wait_core(0, 1'b0, 80);
        chk(8'(timing_err_reg), 8'h1);
        // Reset in mid-run clears the sticky flag; a rushed activate sets it
        t_rst();
        chk(8'(timing_err_reg), 8'h0);
        u_ctrl.issue(CMD_REF, 3'h0, 13'h0, 1'b0);
        u_ctrl.issue(CMD_ACT, 3'h0, 13'h0, 1'b1);
        u_ctrl.issue(CMD_PRE, 3'h0, 13'h0, 1'b0);
        wait_core(0, 1'b1, 20);
        wait_core(0, 1'b0, 40);
        chk(8'(timing_err_reg), 8'h1);
        u_ctrl.issue(CMD_REF, 3'h0, 13'h0, 1'b0);
        u_ctrl.pins(1'b0, 1'b0);
        wait_core(0, 1'b1, 20);
        chk(8'(power_down_reg), 8'h0);
        wait_core(0, 1'b0, 40);
        chk(8'(power_down_reg), 8'h0);
        wait_core(1, 1'b1, 6);
        u_ctrl.pins(1'b1, 1'b0);
        wait_core(1, 1'b0, 10);
    endtask
    // Late flag after the interval limit, cleared by a refresh
    task automatic t_late();
        u_ctrl.issue(CMD_REF, 3'h0, 13'h0, 1'b0);
        wait_core(0, 1'b1, 20);
        wait_core(2, 1'b1, 900);
        chk(8'(n >= 765 && n <= 785), 8'h1);
        @(negedge core_clk);
        high_temp = 1'b1;
        u_ctrl.issue(CMD_REF, 3'h0, 13'h0, 1'b0);
        wait_core(0, 1'b1, 20);
        chk(8'(refresh_late_reg), 8'h0);
        wait_core(2, 1'b1, 500);
        chk(8'(n >= 375 && n <= 395), 8'h1);
    endtask
    initial begin
        core_ce = 1'b1;
        high_temp = 1'b0;
        zq_target = 6'h20;
        t_rst();
        t_write();
        t_odt();
        t_zq();
        t_mpr();
        t_level();
        t_refresh();
        t_late();
        complete_run();
    end
endmodule
